// ---- rtl/backlight_supervisory_control.sv ----
// supervisory control: enable timing, lockouts, low-voltage mode, fault and strap outputs
// Overview of operation
// R1 - enable high powers regulator and runs; enable low shuts down after delay
// R2 - shutdown completes 12.8 ms after enable falls, within 11.5 to 14.1 ms
// R3 - host holds enable high at least 5 ms for a reliable enable; host_model holds it only MIN_ON + 1 = 9 cycles
// R4 - boost enabled only while input and core regulator are above lockout
// R5 - boost disabled whenever input falls below lockout, in any phase
// R6 - input below low-voltage falling threshold enters low-voltage mode, raises limit
// R7 - low-voltage mode lowers frequency only if programmed above 1.4 MHz
// R8 - in low-voltage mode four consecutive overcurrent cycles start 100 ms timer
// R9 - timer expiry returns current limit to the standard limit
// R10 - input above rising threshold leaves low-voltage mode, normal frequency
// R11 - reduced input operation allowed only after soft-start completes; code allows it in RUN, also when re-entered from shutdown without soft-start
// R12 - above load-dump threshold series gate follows input, charge pump stops; only charge_pump_en_r is driven, there is no series gate output
// R13 - fault output pulled low on any fault, released otherwise
// R14 - short detection disabled when threshold pin is strapped to core regulator
// R15 - ac-coupled external clock on timing pin synchronizes switching frequency
// R16 - pwm brightness input tracked, pulses down to 300 ns resolved
// R17 - overcurrent counter clears on cycle under limit or low-voltage exit
module backlight_supervisory_control
   import bl_sup_pkg::*;
#(
   parameter int OFF_DELAY = OFF_DELAY_CYC,
   parameter int LV_TIMER = LV_TIMER_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic enable_pin,
   input wire supply_mon_t mon,
   input wire logic soft_start_done,
   input wire logic cycle_end,
   input wire logic cycle_over_limit,
   input wire logic [11:0] freq_prog_khz,
   input wire logic timing_resistor_pin,
   input wire logic short_threshold_pin,
   input wire logic fault_any,
   input wire logic pwm_brightness_input,
   output logic regulator_en_r,
   output boost_ctl_t boost_r,
   output logic charge_pump_en_r,
   output logic short_detect_en_r,
   output logic pwm_dim_r,
   output logic fault_out_n_o,
   output logic fault_out_n_oe_n_r
);
   // refused at elaboration: a zero delay would wrap the terminal count to all ones
   if (OFF_DELAY < 1 || LV_TIMER < 1) begin : g_bad_timer
      $error("timer parameters must be positive");
   end

   phase_t phase_r;
   logic [31:0] off_cnt_r;
   logic [31:0] lv_cnt_r;
   logic [2:0] oc_cnt_r;
   logic lv_mode_r;
   logic lv_timer_run_r;
   logic ext_clk_s1_r;
   logic ext_clk_s2_r;
   logic ext_clk_prev_r;
   logic [7:0] ext_seen_cnt_r;
   logic boost_en_r;
   logic limit_elev_r;
   logic freq_red_r;
   logic sync_ext_r;

   // one flop per field so each concern keeps a single driver
   assign boost_r = '{boost_en: boost_en_r, limit_elevated: limit_elev_r,
      freq_reduced: freq_red_r, sync_ext: sync_ext_r};

   assign fault_out_n_o = 1'b0;

   // enable sequencing
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_r <= OFF;
         off_cnt_r <= '0;
      end else begin
         case (phase_r)
            OFF: begin
               if (enable_pin) begin
                  phase_r <= SOFT_START; // R1
               end
            end
            SOFT_START: begin
               if (!enable_pin) begin
                  phase_r <= SHUTDOWN;
                  off_cnt_r <= '0;
               end else if (soft_start_done) begin
                  phase_r <= RUN; // R11
               end
            end
            RUN: begin
               if (!enable_pin) begin
                  phase_r <= SHUTDOWN;
                  off_cnt_r <= '0;
               end
            end
            SHUTDOWN: begin
               if (enable_pin) begin
                  phase_r <= RUN;
               end else if (off_cnt_r == 32'(OFF_DELAY - 1)) begin
                  phase_r <= OFF; // R2
               end else begin
                  off_cnt_r <= off_cnt_r + 32'h0000_0001;
               end
            end
            default: phase_r <= OFF;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regulator_en_r <= 1'b0;
      end else begin
         regulator_en_r <= enable_pin || (phase_r != OFF && !(phase_r == SHUTDOWN
            && off_cnt_r == 32'(OFF_DELAY - 1))); // R1
      end
   end

   // low-voltage mode only exists in RUN, entered after soft-start or when enable returns in shutdown
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lv_mode_r <= 1'b0;
      end else if (phase_r != RUN || mon.in_above_lv_rise) begin
         lv_mode_r <= 1'b0; // R10
      end else if (mon.in_below_lv_fall) begin
         lv_mode_r <= 1'b1; // R6 R11
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         oc_cnt_r <= '0;
      end else if (!lv_mode_r) begin
         oc_cnt_r <= '0; // R17
      end else if (cycle_end) begin
         if (!cycle_over_limit) begin
            oc_cnt_r <= '0; // R17
         end else if (oc_cnt_r < 3'(OC_COUNT_LIMIT)) begin
            oc_cnt_r <= oc_cnt_r + 3'h1; // R8
         end
      end
   end

   // timer runs once per low-voltage entry; limit stays standard until next entry
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lv_cnt_r <= '0;
         lv_timer_run_r <= 1'b0;
         limit_elev_r <= 1'b0;
      end else if (!lv_mode_r) begin
         lv_cnt_r <= '0;
         lv_timer_run_r <= 1'b0;
         limit_elev_r <= mon.in_below_lv_fall && phase_r == RUN; // R6
      end else if (lv_timer_run_r) begin
         if (lv_cnt_r == 32'(LV_TIMER - 1)) begin
            lv_timer_run_r <= 1'b0;
            limit_elev_r <= 1'b0; // R9
         end else begin
            lv_cnt_r <= lv_cnt_r + 32'h0000_0001;
         end
      end else if (limit_elev_r && oc_cnt_r == 3'(OC_COUNT_LIMIT)) begin
         lv_timer_run_r <= 1'b1; // R8
         lv_cnt_r <= '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         boost_en_r <= 1'b0;
         freq_red_r <= 1'b0;
      end else begin
         boost_en_r <= (phase_r == SOFT_START || phase_r == RUN) && enable_pin
            && mon.in_above_lockout && mon.core_above_lockout; // R4 R5
         freq_red_r <= lv_mode_r && freq_prog_khz > 12'(FREQ_HIGH_KHZ); // R7
      end
   end

   // external sync: edges seen recently select the external clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_clk_s1_r <= 1'b0;
         ext_clk_s2_r <= 1'b0;
         ext_clk_prev_r <= 1'b0;
         ext_seen_cnt_r <= '0;
         sync_ext_r <= 1'b0;
      end else begin
         ext_clk_s1_r <= timing_resistor_pin;
         ext_clk_s2_r <= ext_clk_s1_r;
         ext_clk_prev_r <= ext_clk_s2_r;
         if (ext_clk_s2_r && !ext_clk_prev_r) begin
            ext_seen_cnt_r <= 8'hff;
            sync_ext_r <= 1'b1; // R15
         end else if (ext_seen_cnt_r != 8'h00) begin
            ext_seen_cnt_r <= ext_seen_cnt_r - 8'h01;
         end else begin
            sync_ext_r <= 1'b0;
         end
      end
   end

   // one-cycle sampling at 20 MHz resolves 300 ns pulses (six samples)
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwm_dim_r <= 1'b0;
         charge_pump_en_r <= 1'b0;
         short_detect_en_r <= 1'b0;
         fault_out_n_oe_n_r <= 1'b1;
      end else begin
         pwm_dim_r <= pwm_brightness_input && regulator_en_r; // R16
         charge_pump_en_r <= regulator_en_r && !mon.in_above_load_dump; // R12
         short_detect_en_r <= !short_threshold_pin; // R14
         fault_out_n_oe_n_r <= !fault_any; // R13
      end
   end

   // assertions
   shutdown_delay_a: assert property (@(posedge clk_sys) disable iff (rst) // R2
      phase_r == OFF && $past(phase_r) == SHUTDOWN
      |-> $past(off_cnt_r) == 32'(OFF_DELAY - 1))
      else $error("shutdown ended too early");
   lockout_gate_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
      !mon.in_above_lockout |=> !boost_r.boost_en)
      else $error("boost on below input lockout");
   core_lockout_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
      !mon.core_above_lockout |=> !boost_r.boost_en)
      else $error("boost on below core lockout");
   freq_low_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
      boost_r.freq_reduced |-> $past(freq_prog_khz) > 12'(FREQ_HIGH_KHZ))
      else $error("frequency reduced while programmed low");
   lv_exit_a: assert property (@(posedge clk_sys) disable iff (rst) // R10
      mon.in_above_lv_rise |=> !lv_mode_r ##1 !boost_r.freq_reduced)
      else $error("low-voltage mode not left");
   oc_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // R17
      cycle_end && !cycle_over_limit |=> oc_cnt_r == 3'h0)
      else $error("overcurrent count not cleared");
   lv_after_start_a: assert property (@(posedge clk_sys) disable iff (rst) // R11
      lv_mode_r |-> $past(phase_r) == RUN)
      else $error("low-voltage mode before soft-start end");
   load_dump_a: assert property (@(posedge clk_sys) disable iff (rst) // R12
      mon.in_above_load_dump |=> !charge_pump_en_r)
      else $error("charge pump on during load dump");
   fault_pin_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
      fault_any |=> !fault_out_n_oe_n_r && !fault_out_n_o)
      else $error("fault not driven low");
   strap_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
      short_threshold_pin |=> !short_detect_en_r)
      else $error("short detection on while strapped");
   timer_end_a: assert property (@(posedge clk_sys) disable iff (rst) // R9
      lv_timer_run_r && lv_mode_r && lv_cnt_r == 32'(LV_TIMER - 1)
      |=> !boost_r.limit_elevated)
      else $error("limit not restored at timer end");
endmodule

// ---- rtl/bl_sup_pkg.sv ----
// package: constants and carrier types for the backlight supervisory control
package bl_sup_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int OFF_DELAY_US = 12_800;
   localparam int OFF_DELAY_CYC = OFF_DELAY_US * (CLK_HZ / 1_000_000);
   localparam int LV_TIMER_MS = 100;
   localparam int LV_TIMER_CYC = LV_TIMER_MS * (CLK_HZ / 1_000);
   localparam int OC_COUNT_LIMIT = 4;
   localparam int FREQ_HIGH_KHZ = 1_400;
   localparam logic [1:0] ST_OFF = 2'h0;

   // analog comparator outputs, taken as synchronous levels
   typedef struct packed {
      logic in_above_lockout;
      logic core_above_lockout;
      logic in_below_lv_fall;
      logic in_above_lv_rise;
      logic in_above_load_dump;
   } supply_mon_t;

   // controls handed to the boost converter
   typedef struct packed {
      logic boost_en;
      logic limit_elevated;
      logic freq_reduced;
      logic sync_ext;
   } boost_ctl_t;

   typedef enum logic [1:0] {
      OFF = 2'b00,
      SOFT_START = 2'b01,
      RUN = 2'b10,
      SHUTDOWN = 2'b11
   } phase_t;
endpackage

// ---- test/host_model.sv ----
// host side model: drives the enable pin and watches the open-drain fault pin
module host_model #(
   parameter int MIN_ON = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic want_on,
   input wire logic fault_pin,
   output logic enable_pin = 1'b0,
   output logic fault_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   int hold = 0;

   // a short enable pulse may not start the device, so each one is stretched
   always @(negedge clk_sys) begin
      if (rst) begin
         enable_pin <= 1'b0;
         hold <= 0;
      end else if (want_on && !enable_pin) begin
         enable_pin <= 1'b1;
         hold <= MIN_ON;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end else begin
         enable_pin <= want_on;
      end
   end

   // the pull-up lifts the pin, so low means a fault
   assign fault_seen = ~fault_pin;
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the backlight supervisory control
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import bl_sup_pkg::*;
   localparam int OFF_D = 20;
   localparam int LV_T = 30;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic want_on = 1'b0;
   logic ssd = 1'b0;
   logic cyc_end = 1'b0;
   logic cyc_ovr = 1'b0;
   logic trp = 1'b0;
   logic stp = 1'b0;
   logic flt = 1'b0;
   logic pwm = 1'b0;
   supply_mon_t mon = '0;
   logic [11:0] fkhz = 12'h0000;
   logic reg_en, cp_en, sd_en, pwm_q, fo, fo_oe_n, en_pin, fault_seen, fault_wire;
   boost_ctl_t bst;
   int fails = 0;
   int n_tests = 0;
   int seed = 18;

   // released pin is pulled up
   assign fault_wire = fo_oe_n ? 1'b1 : fo;

   initial forever #25 clk_sys = ~clk_sys;

   backlight_supervisory_control #(.OFF_DELAY(OFF_D), .LV_TIMER(LV_T)) dut (
      .clk_sys(clk_sys), .rst(rst), .enable_pin(en_pin), .mon(mon),
      .soft_start_done(ssd), .cycle_end(cyc_end), .cycle_over_limit(cyc_ovr),
      .freq_prog_khz(fkhz), .timing_resistor_pin(trp), .short_threshold_pin(stp),
      .fault_any(flt), .pwm_brightness_input(pwm), .regulator_en_r(reg_en),
      .boost_r(bst), .charge_pump_en_r(cp_en), .short_detect_en_r(sd_en),
      .pwm_dim_r(pwm_q), .fault_out_n_o(fo), .fault_out_n_oe_n_r(fo_oe_n));

   host_model #(.MIN_ON(8)) host (
      .clk_sys(clk_sys), .rst(rst), .want_on(want_on), .fault_pin(fault_wire),
      .enable_pin(en_pin), .fault_seen(fault_seen));

   function automatic logic exp_reduced(input logic [11:0] f);
      return int'(f) > FREQ_HIGH_KHZ;
   endfunction

   task automatic chk(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic pulse(input logic ovr);
      cyc_end = 1'b1;
      cyc_ovr = ovr;
      cyc(1);
      cyc_end = 1'b0;
      cyc(1);
   endtask

   task automatic lv_enter(input logic [11:0] f);
      fkhz = f;
      mon.in_above_lv_rise = 1'b0;
      mon.in_below_lv_fall = 1'b1;
      cyc(4);
   endtask

   task automatic lv_leave();
      mon.in_below_lv_fall = 1'b0;
      mon.in_above_lv_rise = 1'b1;
      cyc(4);
   endtask

   task automatic finish_test;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // the whole sequence needs well under 1000 cycles
   initial begin
      #(3000 * 50);
      fails++;
      finish_test;
   end

   initial begin
      cyc(16);
      rst = 1'b0;
      chk(fo_oe_n, 1'b1);
      mon.core_above_lockout = 1'b1;
      want_on = 1'b1;
      cyc(4);
      chk(reg_en, 1'b1);
      chk(bst.boost_en, 1'b0);
      mon.in_above_lockout = 1'b1;
      cyc(3);
      chk(bst.boost_en, 1'b1);
      lv_enter(12'h07d0);
      chk(bst.limit_elevated, 1'b0);
      ssd = 1'b1;
      cyc(4);
      chk(bst.limit_elevated, 1'b1);
      chk(bst.freq_reduced, exp_reduced(fkhz));
      // a clean cycle in the middle must restart the count
      repeat (3) pulse(1'b1);
      pulse(1'b0);
      cyc(LV_T + 5);
      chk(bst.limit_elevated, 1'b1);
      repeat (4) pulse(1'b1);
      cyc(LV_T - 6);
      chk(bst.limit_elevated, 1'b1);
      cyc(12);
      chk(bst.limit_elevated, 1'b0);
      lv_leave();
      chk(bst.freq_reduced, 1'b0);
      lv_enter(12'h0578);
      chk(bst.limit_elevated, 1'b1);
      chk(bst.freq_reduced, exp_reduced(fkhz));
      lv_leave();
      mon.in_above_lockout = 1'b0;
      cyc(3);
      chk(bst.boost_en, 1'b0);
      mon.in_above_lockout = 1'b1;
      mon.in_above_load_dump = 1'b1;
      cyc(3);
      chk(cp_en, 1'b0);
      mon.in_above_load_dump = 1'b0;
      flt = 1'b1;
      cyc(3);
      chk(cp_en, 1'b1);
      chk(fault_seen, 1'b1);
      flt = 1'b0;
      stp = 1'b1;
      cyc(3);
      chk(fault_seen, 1'b0);
      chk(sd_en, 1'b0);
      stp = 1'b0;
      cyc(3);
      chk(sd_en, 1'b1);
      repeat (12) begin
         trp = ~trp;
         cyc(4);
      end
      chk(bst.sync_ext, 1'b1);
      cyc(300);
      chk(bst.sync_ext, 1'b0);
      repeat (40) begin
         pwm = 1'($random(seed));
         cyc(1);
         chk(pwm_q, pwm);
      end
      want_on = 1'b0;
      cyc(2);
      chk(bst.boost_en, 1'b0);
      cyc(OFF_D - 6);
      chk(reg_en, 1'b1);
      cyc(10);
      chk(reg_en, 1'b0);
      finish_test;
   end
endmodule
